// File: hdl/opm_pkg.sv
// Constants, types and register map of the oscillator and power-mode controller
// Operation
// - Drive range bit 0 is weak drive up to 10MHz; 1 is strong drive above.
// - Drive range writes ignored while crystal pins assigned and crystal enabled.
// - High-speed stable flag clears on enable, sets once oscillator is stable.
// - High-speed control bit 0 turns crystal off/on; all bits reset to 0.
// - Bits 7 to 3 of both crystal control registers read as zero.
// - Fast start bit: 0 low power slow start, 1 fast start; resets 0.
// - Fast start bit frozen while low-speed crystal drives the system clock.
// - Low-speed stable flag clears on enable, sets once oscillator is stable.
// - Low-speed control bit 0 disables/enables crystal; resets to 0.
// - Divider code all ones moves system clock to sub clock, SLOW mode.
// - SLOW switch completes only after the selected low-speed source is stable.
// - Codes 000 to 110 return to high clock divided by 1 to 64.
// - Return to FAST waits for a stopped high clock to restart.
// - Keep bits pick SLEEP, sub-only, both-clocks or high-only halt mode.
// - SLEEP stops all clocks and functions except an enabled watchdog.
// - Sub-only halt stops high clock and CPU, sub clock keeps running.
// - Both-clocks halt keeps both clocks running with the CPU halted.
// - High-only halt keeps high clock, stops sub clock, CPU halted.
// - Halt entry keeps memory, registers and port states unchanged.
// - Halt entry sets the powerdown flag and clears the watchdog expiry flag.
// - Halt entry clears watchdog counter; it runs on only if enabled.
// - Source picks: high 0 RC, 1 crystal; low 0 RC, 1 crystal.
package opm_pkg;
    localparam logic [7:0] ADDR_SCC  = 8'h00;
    localparam logic [7:0] ADDR_HS_CRYSTAL_CTRL = 8'h04;
    localparam logic [7:0] ADDR_LP_CRYSTAL_CTRL = 8'h08;
    localparam logic [7:0] ADDR_STAT = 8'h0C;
    localparam logic [7:0] ADDR_MISC = 8'h10;

    localparam int SCC_DIV_LSB = 5;
    localparam int SCC_FHS     = 3;
    localparam int SCC_FSS     = 2;
    localparam int SCC_HKEEP   = 1;
    localparam int SCC_LKEEP   = 0;
    localparam int XT_MODE     = 2;
    localparam int XT_STABLE   = 1;
    localparam int XT_ON       = 0;
    localparam int ST_PWD      = 3;
    localparam int ST_WDX      = 4;
    localparam int ST_BUSY     = 5;
    localparam int ST_SUB      = 6;
    localparam int MISC_PINS   = 0;
    localparam int MISC_WDEN   = 1;

    localparam logic [2:0] DIV_SUB   = 3'h7;
    localparam logic [2:0] DIV_RESET = 3'h0;
    localparam logic [7:0] SCC_RESET = 8'h00;

    // Switch gap in system clock periods
    localparam int SWITCH_GAP_TSYS = 4;
    localparam int SYS_PERIOD_NS   = 4;
    localparam int GAP_CYC = (SWITCH_GAP_TSYS * SYS_PERIOD_NS + SYS_PERIOD_NS - 1)
                             / SYS_PERIOD_NS;
    localparam logic [2:0] GAP_LOAD = 3'(GAP_CYC - 1);

    typedef enum logic [2:0] {
        PM_RUN, PM_SLEEP, PM_SUB_ONLY, PM_BOTH, PM_HIGH_ONLY
    } opm_pmode_t;

    typedef enum logic [1:0] {SW_RUN, SW_WAIT, SW_GAP} opm_sw_t;

    typedef struct packed {
        logic hs_crystal_ready;
        logic hs_rc_stable;
        logic lp_crystal_ready;
        logic lp_rc_ready;
    } opm_osc_stat_t;

    typedef struct packed {
        logic       hs_crystal_en;
        logic       crystal_drive_range;
        logic       lp_crystal_en;
        logic       lp_crystal_fast_start;
        logic       high_clock_run;
        logic       sub_clock_run;
        logic       lp_rc_run;
        logic       sys_clk_gate;
        logic       sys_use_sub;
        logic       sys_use_crystal;
        logic [2:0] sys_div;
        logic       cpu_run;
    } opm_clk_out_t;
endpackage

// File: hdl/opm_ctrl.sv
// Oscillator enables, system clock switching and halt mode control
`timescale 1ns/100ps
module opm_ctrl (
    input  wire logic                  clock,
    input  wire logic                  rst_b,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [7:0]            paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire opm_pkg::opm_osc_stat_t osc,
    input  wire logic                  halt_req,
    input  wire logic                  wake_req,
    input  wire logic                  wdog_clear_cmd,
    input  wire logic                  wdog_timeout,
    output opm_pkg::opm_clk_out_t      clk_out,
    output logic                       watchdog_counter_clear,
    output logic                       watchdog_counter_run,
    output logic                       powerdown_flag,
    output logic                       wdog_expiry_flag
);
    import opm_pkg::*;

    function automatic logic is_mapped(input logic [7:0] a);
        return a == ADDR_SCC || a == ADDR_HS_CRYSTAL_CTRL || a == ADDR_LP_CRYSTAL_CTRL ||
               a == ADDR_STAT || a == ADDR_MISC;
    endfunction

    // Stability of the source behind a divider/source setting
    function automatic logic src_ok(input logic [2:0] dv, input logic fh,
                                    input logic fs, input logic hst,
                                    input logic lst, input opm_osc_stat_t o);
        if (dv == DIV_SUB)
            return fs ? lst : o.lp_rc_ready;
        return fh ? hst : o.hs_rc_stable;
    endfunction

    // APB slave: no wait state, answer in first access cycle
    logic        pready_q, pready_d;
    logic        pslverr_q, pslverr_d;
    logic [31:0] prdata_q, prdata_d;
    logic        wr_en;

    // Software registers
    logic [7:0] scc_q, scc_d;
    logic       hs_on_q, hs_on_d;
    logic       range_q, range_d;
    logic       hs_stable_q, hs_stable_d;
    logic       lp_on_q, lp_on_d;
    logic       fast_q, fast_d;
    logic       lp_stable_q, lp_stable_d;
    logic       pins_q, pins_d;
    logic       wden_q, wden_d;
    logic       pwd_q, pwd_d;
    logic       wdx_q, wdx_d;

    // Clock switch state
    opm_sw_t    sw_q, sw_d;
    logic [2:0] gap_q, gap_d;
    logic [2:0] act_div_q, act_div_d;
    logic       act_fhs_q, act_fhs_d;
    logic       act_fss_q, act_fss_d;
    logic       gate_q, gate_d;

    // Power mode state
    opm_pmode_t pm_q, pm_d;
    logic       wclr_q, wclr_d;
    opm_clk_out_t out_q, out_d;

    logic [2:0] tgt_div;
    logic       tgt_fhs;
    logic       tgt_fss;
    logic       halt_go;
    logic       lxt_is_sys;

    assign tgt_div    = scc_q[SCC_DIV_LSB +: 3];
    assign tgt_fhs    = scc_q[SCC_FHS];
    assign tgt_fss    = scc_q[SCC_FSS];
    assign wr_en      = psel & penable & pready_q & pwrite;
    assign halt_go    = halt_req & (pm_q == PM_RUN);
    assign lxt_is_sys = (act_div_q == DIV_SUB) & act_fss_q;

    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;
    assign clk_out = out_q;
    assign watchdog_counter_clear = wclr_q;
    assign watchdog_counter_run   = wden_q;
    assign powerdown_flag         = pwd_q;
    assign wdog_expiry_flag       = wdx_q;

    always_comb begin
        pready_d  = psel & ~penable & ~pready_q;
        pslverr_d = 1'b0;
        prdata_d  = prdata_q;
        if (psel & ~penable) begin
            pslverr_d = ~is_mapped(paddr);
            prdata_d  = 32'h0000_0000;
            if (!pwrite) begin
                unique case (paddr)
                    ADDR_SCC:  prdata_d[7:0] = {scc_q[7:5], 1'b0, scc_q[3:0]};
                    // Upper bits of both crystal registers read zero
                    ADDR_HS_CRYSTAL_CTRL: prdata_d[2:0] = {range_q, hs_stable_q, hs_on_q};
                    ADDR_LP_CRYSTAL_CTRL: prdata_d[2:0] = {fast_q, lp_stable_q, lp_on_q};
                    ADDR_STAT: begin
                        prdata_d[2:0]     = pm_q;
                        prdata_d[ST_PWD]  = pwd_q;
                        prdata_d[ST_WDX]  = wdx_q;
                        prdata_d[ST_BUSY] = sw_q != SW_RUN;
                        prdata_d[ST_SUB]  = act_div_q == DIV_SUB;
                    end
                    ADDR_MISC: begin
                        prdata_d[MISC_PINS] = pins_q;
                        prdata_d[MISC_WDEN] = wden_q;
                    end
                    default: prdata_d = 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else begin
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
            prdata_q  <= prdata_d;
        end
    end

    always_comb begin
        scc_d   = scc_q;
        hs_on_d = hs_on_q;
        range_d = range_q;
        lp_on_d = lp_on_q;
        fast_d  = fast_q;
        pins_d  = pins_q;
        wden_d  = wden_q;
        if (wr_en) begin
            unique case (paddr)
                ADDR_SCC: scc_d = {pwdata[7:5], 1'b0, pwdata[3:0]};
                ADDR_HS_CRYSTAL_CTRL: begin
                    hs_on_d = pwdata[XT_ON];
                    // Pins and enable both set lock the range
                    if (!(pins_q && hs_on_q))
                        range_d = pwdata[XT_MODE];
                end
                ADDR_LP_CRYSTAL_CTRL: begin
                    lp_on_d = pwdata[XT_ON];
                    if (!lxt_is_sys)
                        fast_d = pwdata[XT_MODE];
                end
                ADDR_MISC: begin
                    pins_d = pwdata[MISC_PINS];
                    wden_d = pwdata[MISC_WDEN];
                end
                default: ;
            endcase
        end
        // Flag follows enable: low on enable, high once oscillator settles
        hs_stable_d = hs_on_q & osc.hs_crystal_ready;
        lp_stable_d = lp_on_q & osc.lp_crystal_ready;
        // Hardware set wins over software clear
        pwd_d = pwd_q;
        if (wdog_clear_cmd)
            pwd_d = 1'b0;
        if (halt_go)
            pwd_d = 1'b1;
        wdx_d = wdx_q;
        if (halt_go)
            wdx_d = 1'b0;
        if (wdog_timeout)
            wdx_d = 1'b1;
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            scc_q       <= SCC_RESET;
            hs_on_q     <= 1'b0;
            range_q     <= 1'b0;
            hs_stable_q <= 1'b0;
            lp_on_q     <= 1'b0;
            fast_q      <= 1'b0;
            lp_stable_q <= 1'b0;
            pins_q      <= 1'b0;
            wden_q      <= 1'b1;
            pwd_q       <= 1'b0;
            wdx_q       <= 1'b0;
        end else begin
            scc_q       <= scc_d;
            hs_on_q     <= hs_on_d;
            range_q     <= range_d;
            hs_stable_q <= hs_stable_d;
            lp_on_q     <= lp_on_d;
            fast_q      <= fast_d;
            lp_stable_q <= lp_stable_d;
            pins_q      <= pins_d;
            wden_q      <= wden_d;
            pwd_q       <= pwd_d;
            wdx_q       <= wdx_d;
        end
    end

    // Switch: wait for target stable, gate low for the gap, then commit.
    // Gate stays low the whole gap so no runt pulse reaches the CPU.
    always_comb begin
        sw_d      = sw_q;
        gap_d     = gap_q;
        act_div_d = act_div_q;
        act_fhs_d = act_fhs_q;
        act_fss_d = act_fss_q;
        gate_d    = gate_q;
        unique case (sw_q)
            SW_RUN: begin
                if (tgt_div != act_div_q || tgt_fhs != act_fhs_q ||
                    tgt_fss != act_fss_q)
                    sw_d = SW_WAIT;
            end
            SW_WAIT: begin
                // Old clock keeps running until the target has settled
                if (src_ok(tgt_div, tgt_fhs, tgt_fss, hs_stable_q,
                           lp_stable_q, osc)) begin
                    sw_d   = SW_GAP;
                    gap_d  = GAP_LOAD;
                    gate_d = 1'b0;
                end
            end
            SW_GAP: begin
                if (gap_q == 3'h0) begin
                    act_div_d = tgt_div;
                    act_fhs_d = tgt_fhs;
                    act_fss_d = tgt_fss;
                    gate_d    = 1'b1;
                    sw_d      = SW_RUN;
                end else begin
                    gap_d = gap_q - 3'h1;
                end
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            sw_q      <= SW_RUN;
            gap_q     <= 3'h0;
            act_div_q <= DIV_RESET;
            act_fhs_q <= 1'b0;
            act_fss_q <= 1'b0;
            gate_q    <= 1'b1;
        end else begin
            sw_q      <= sw_d;
            gap_q     <= gap_d;
            act_div_q <= act_div_d;
            act_fhs_q <= act_fhs_d;
            act_fss_q <= act_fss_d;
            gate_q    <= gate_d;
        end
    end

    // Halt entry gates clocks, sets the powerdown flag, clears the expiry flag and pulses the watchdog clear
    always_comb begin
        pm_d   = pm_q;
        wclr_d = halt_go;
        if (halt_go) begin
            unique case ({scc_q[SCC_HKEEP], scc_q[SCC_LKEEP]})
                2'b00: pm_d = PM_SLEEP;
                2'b01: pm_d = PM_SUB_ONLY;
                2'b11: pm_d = PM_BOTH;
                2'b10: pm_d = PM_HIGH_ONLY;
            endcase
        end else if (wake_req) begin
            pm_d = PM_RUN;
        end
        out_d.crystal_drive_range   = range_q;
        out_d.lp_crystal_fast_start = fast_q;
        out_d.sys_clk_gate          = gate_q & (pm_q == PM_RUN);
        out_d.sys_use_sub           = act_div_q == DIV_SUB;
        out_d.sys_use_crystal       = act_div_q == DIV_SUB ? act_fss_q : act_fhs_q;
        out_d.sys_div               = act_div_q;
        out_d.cpu_run               = pm_q == PM_RUN;
        unique case (pm_q)
            PM_RUN: begin
                // In SLOW the high clock runs only if its oscillator is on or a return from SLOW is pending
                out_d.high_clock_run = act_div_q != DIV_SUB || hs_on_q ||
                                       tgt_div != DIV_SUB;
                out_d.sub_clock_run  = 1'b1;
            end
            PM_SLEEP: begin
                out_d.high_clock_run = 1'b0;
                out_d.sub_clock_run  = 1'b0;
            end
            PM_SUB_ONLY: begin
                out_d.high_clock_run = 1'b0;
                out_d.sub_clock_run  = 1'b1;
            end
            PM_BOTH: begin
                out_d.high_clock_run = 1'b1;
                out_d.sub_clock_run  = 1'b1;
            end
            PM_HIGH_ONLY: begin
                out_d.high_clock_run = 1'b1;
                out_d.sub_clock_run  = 1'b0;
            end
            default: begin
                out_d.high_clock_run = 1'b0;
                out_d.sub_clock_run  = 1'b0;
            end
        endcase
        out_d.hs_crystal_en = hs_on_q & out_d.high_clock_run;
        out_d.lp_crystal_en = lp_on_q & out_d.sub_clock_run;
        // Watchdog RC survives every mode while the watchdog is enabled
        out_d.lp_rc_run = out_d.sub_clock_run | wden_q;
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            pm_q   <= PM_RUN;
            wclr_q <= 1'b0;
            out_q  <= '{sys_clk_gate: 1'b1, high_clock_run: 1'b1,
                        sub_clock_run: 1'b1, lp_rc_run: 1'b1,
                        cpu_run: 1'b1, sys_div: DIV_RESET, default: 1'b0};
        end else begin
            pm_q   <= pm_d;
            wclr_q <= wclr_d;
            out_q  <= out_d;
        end
    end
endmodule

// File: verification/opm_osc_model.sv
// Behavioural crystal and RC oscillators at the far side of the controller
`timescale 1ns/100ps
module opm_osc_model
    import opm_pkg::*;
#(
    parameter int HS_DLY      = 20,
    parameter int LP_SLOW_DLY = 60,
    parameter int LP_FAST_DLY = 12
) (
    input  wire logic                  clock,
    input  wire logic                  rst_b,
    input  wire opm_pkg::opm_clk_out_t clk_out,
    output opm_pkg::opm_osc_stat_t     osc
);
    int hs_cnt;
    int lp_cnt;

    // Counts saturate so a long run never wraps back to unstable
    always @(posedge clock) begin
        hs_cnt <= (!rst_b || !clk_out.hs_crystal_en) ? 0 : hs_cnt + int'(hs_cnt < 1000);
        lp_cnt <= (!rst_b || !clk_out.lp_crystal_en) ? 0 : lp_cnt + int'(lp_cnt < 1000);
    end

    assign osc.hs_crystal_ready = hs_cnt >= HS_DLY;
    // Fast start buys a shorter start-up at higher current
    assign osc.lp_crystal_ready = lp_cnt >= (clk_out.lp_crystal_fast_start ?
                                             LP_FAST_DLY : LP_SLOW_DLY);
    assign osc.hs_rc_stable     = clk_out.high_clock_run;
    assign osc.lp_rc_ready      = clk_out.lp_rc_run;
endmodule

// File: verification/opm_ctrl_assertions.sv
// Concurrent checks on the controller ports
`timescale 1ns/100ps
module opm_ctrl_assertions
    import opm_pkg::*;
(
    input wire logic                   clock,
    input wire logic                   rst_b,
    input wire logic                   psel,
    input wire logic                   penable,
    input wire logic                   pwrite,
    input wire logic [7:0]             paddr,
    input wire logic [31:0]            pwdata,
    input wire logic [31:0]            prdata,
    input wire logic                   pready,
    input wire opm_pkg::opm_osc_stat_t osc,
    input wire logic                   halt_req,
    input wire logic                   wdog_timeout,
    input wire opm_pkg::opm_clk_out_t  clk_out,
    input wire logic                   watchdog_counter_clear,
    input wire logic                   watchdog_counter_run,
    input wire logic                   powerdown_flag,
    input wire logic                   wdog_expiry_flag
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    logic hwr;
    logic hgo;
    assign hwr = psel && penable && pready && pwrite && paddr == ADDR_HS_CRYSTAL_CTRL;
    assign hgo = halt_req && clk_out.cpu_run;

    property p_apb_ready;
        psel && !penable |=> pready ##1 !pready;
    endproperty
    a_apb_ready: assert property (p_apb_ready)
        else $error("pready not a single cycle after setup");
    property p_read_zero;
        pready && !pwrite && (paddr == ADDR_HS_CRYSTAL_CTRL || paddr == ADDR_LP_CRYSTAL_CTRL) |-> prdata[7:3] == 5'h00;
    endproperty
    a_read_zero: assert property (p_read_zero)
        else $error("unused crystal bits read nonzero");
    property p_hs_on;
        hwr && pwdata[0] && clk_out.high_clock_run |-> ##[1:2] clk_out.hs_crystal_en;
    endproperty
    a_hs_on: assert property (p_hs_on)
        else $error("crystal enable not applied");
    property p_range;
        hwr && pwdata[2] && !clk_out.hs_crystal_en |-> ##[1:2] clk_out.crystal_drive_range;
    endproperty
    a_range: assert property (p_range)
        else $error("drive range not applied");
    property p_flags;
        hgo && !wdog_timeout |=> powerdown_flag && !wdog_expiry_flag;
    endproperty
    a_flags: assert property (p_flags)
        else $error("halt flags wrong");
    property p_wd_clear;
        hgo |=> watchdog_counter_clear ##1 !watchdog_counter_clear;
    endproperty
    a_wd_clear: assert property (p_wd_clear)
        else $error("watchdog clear pulse wrong");
    property p_stop;
        hgo |=> ##1 !clk_out.cpu_run && !clk_out.sys_clk_gate;
    endproperty
    a_stop: assert property (p_stop)
        else $error("cpu not halted");
    property p_sleep_rc;
        !clk_out.cpu_run && !clk_out.high_clock_run && !clk_out.sub_clock_run
            |-> clk_out.lp_rc_run == watchdog_counter_run;
    endproperty
    a_sleep_rc: assert property (p_sleep_rc)
        else $error("watchdog clock wrong in sleep");
    property p_glitch;
        $past(rst_b) && ($changed(clk_out.sys_div) || $changed(clk_out.sys_use_sub))
            |-> !$past(clk_out.sys_clk_gate);
    endproperty
    a_glitch: assert property (p_glitch)
        else $error("clock source changed without gap");
    property p_sub_ready;
        $rose(clk_out.sys_use_sub)
            |-> (clk_out.sys_use_crystal ? osc.lp_crystal_ready : osc.lp_rc_ready);
    endproperty
    a_sub_ready: assert property (p_sub_ready)
        else $error("sub clock taken before stable");
endmodule

bind opm_ctrl opm_ctrl_assertions opm_ctrl_assertions_i (
    .clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .osc(osc),
    .halt_req(halt_req), .wdog_timeout(wdog_timeout), .clk_out(clk_out),
    .watchdog_counter_clear(watchdog_counter_clear),
    .watchdog_counter_run(watchdog_counter_run), .powerdown_flag(powerdown_flag),
    .wdog_expiry_flag(wdog_expiry_flag)
);

// File: verification/tb_osc_and_power_mode_control.sv
// Self-checking bench for the oscillator and power-mode controller
`timescale 1ns/100ps
module tb_osc_and_power_mode_control;
    import opm_pkg::*;
    logic          clock, rst_b, psel, penable, pwrite, pready, pslverr;
    logic          halt_req, wake_req, wdog_clear_cmd, wdog_timeout;
    logic          wd_clr, wd_run, pd_flag, ex_flag, er;
    logic [7:0]    paddr;
    logic [31:0]   pwdata, prdata, rd;
    opm_osc_stat_t osc;
    opm_clk_out_t  co;
    int            miscompares, samples_checked;

    opm_ctrl opm_ctrl_i (.clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .osc(osc), .halt_req(halt_req), .wake_req(wake_req),
        .wdog_clear_cmd(wdog_clear_cmd), .wdog_timeout(wdog_timeout), .clk_out(co),
        .watchdog_counter_clear(wd_clr), .watchdog_counter_run(wd_run),
        .powerdown_flag(pd_flag), .wdog_expiry_flag(ex_flag));
    opm_osc_model opm_osc_model_i (.clock(clock), .rst_b(rst_b), .clk_out(co), .osc(osc));

    task automatic final_report;
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            $display("BAD %s expected %h seen %h", nm, e, g);
            miscompares++;
        end
    endtask
    // Request held until pready is sampled high or 50 cycles pass, never a fixed latency
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) miscompares++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string nm);
        apb(1'b0, a, 32'h0);
        chk(nm, e, rd);
    endtask
    task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
        int k;
        k = 0;
        do begin
            apb(1'b0, a, 32'h0);
            k++;
        end while ((rd & m) !== v && k < 100);
        chk("poll", v, rd & m);
    endtask
    task automatic pulse_at(input int which);
        @(posedge clock);
        if (which == 0) wake_req <= 1'b1;
        else wdog_clear_cmd <= 1'b1;
        @(posedge clock);
        wake_req <= 1'b0;
        wdog_clear_cmd <= 1'b0;
    endtask

    task automatic t_regs;
        rchk(ADDR_HS_CRYSTAL_CTRL, 32'h0, "hs_ctrl");
        rchk(ADDR_LP_CRYSTAL_CTRL, 32'h0, "lp_ctrl");
        apb(1'b0, 8'h20, 32'h0);
        chk("unmapped_err", 32'h1, er);
    endtask
    task automatic t_hs;
        apb(1'b1, ADDR_MISC, 32'h3);
        apb(1'b1, ADDR_HS_CRYSTAL_CTRL, 32'h4);
        rchk(ADDR_HS_CRYSTAL_CTRL, 32'h4, "range_set");
        apb(1'b1, ADDR_HS_CRYSTAL_CTRL, 32'h5);
        rchk(ADDR_HS_CRYSTAL_CTRL, 32'h5, "hs_unstable");
        poll(ADDR_HS_CRYSTAL_CTRL, 32'h2, 32'h2);
        apb(1'b1, ADDR_HS_CRYSTAL_CTRL, 32'h1);
        rchk(ADDR_HS_CRYSTAL_CTRL, 32'h7, "range_locked");
        chk("range_out", 32'h1, co.crystal_drive_range);
        apb(1'b1, ADDR_MISC, 32'h2);
        apb(1'b1, ADDR_HS_CRYSTAL_CTRL, 32'h1);
        rchk(ADDR_HS_CRYSTAL_CTRL, 32'h3, "range_free");
    endtask
    task automatic t_slow;
        apb(1'b1, ADDR_LP_CRYSTAL_CTRL, 32'h5);
        rchk(ADDR_LP_CRYSTAL_CTRL, 32'h5, "lp_unstable");
        apb(1'b1, ADDR_SCC, 32'hE4);
        poll(ADDR_STAT, 32'h60, 32'h40);
        chk("use_sub", 32'h1, co.sys_use_sub);
        apb(1'b1, ADDR_LP_CRYSTAL_CTRL, 32'h1);
        rchk(ADDR_LP_CRYSTAL_CTRL, 32'h7, "fast_frozen");
        chk("fast_out", 32'h1, co.lp_crystal_fast_start);
        apb(1'b1, ADDR_HS_CRYSTAL_CTRL, 32'h0);
        repeat (3) @(posedge clock);
        chk("high_off", 32'h0, co.high_clock_run);
        apb(1'b1, ADDR_HS_CRYSTAL_CTRL, 32'h1);
        apb(1'b1, ADDR_SCC, 32'h2C);
        poll(ADDR_STAT, 32'h60, 32'h0);
        chk("div", 32'h1, co.sys_div);
        chk("use_xtal", 32'h1, co.sys_use_crystal);
        apb(1'b1, ADDR_LP_CRYSTAL_CTRL, 32'h1);
        rchk(ADDR_LP_CRYSTAL_CTRL, 32'h3, "fast_free");
    endtask
    task automatic t_halt(input logic [1:0] k, input logic [2:0] m);
        apb(1'b1, ADDR_SCC, 32'h2C | k);
        @(posedge clock);
        wdog_timeout <= 1'b1;
        @(posedge clock);
        wdog_timeout <= 1'b0;
        halt_req <= 1'b1;
        @(posedge clock);
        halt_req <= 1'b0;
        repeat (2) @(posedge clock);
        #1;
        chk("pd_flag", 32'h1, pd_flag);
        chk("ex_flag", 32'h0, ex_flag);
        chk("cpu_run", 32'h0, co.cpu_run);
        chk("high_run", k[1], co.high_clock_run);
        chk("sub_run", k[0], co.sub_clock_run);
        chk("wd_run", 32'h1, wd_run);
        rchk(ADDR_STAT, 32'h08 | m, "mode");
        pulse_at(0);
        pulse_at(1);
        rchk(ADDR_SCC, 32'h2C | k, "scc_kept");
        chk("pd_clear", 32'h0, pd_flag);
        chk("cpu_back", 32'h1, co.cpu_run);
    endtask

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    initial begin
        #200000;
        miscompares++;
        final_report();
    end
    initial begin
        {rst_b, psel, penable, pwrite, halt_req, wake_req, wdog_clear_cmd, wdog_timeout} = '0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (4) @(posedge clock);
        rst_b <= 1'b1;
        t_regs();
        t_hs();
        t_slow();
        t_halt(2'b00, PM_SLEEP);
        t_halt(2'b01, PM_SUB_ONLY);
        t_halt(2'b11, PM_BOTH);
        t_halt(2'b10, PM_HIGH_ONLY);
        final_report();
    end
endmodule
